/* File: hdl/hcb_cfg.svh */
/*
  offsets, field positions, reset values for the hdlc channel block.
  assumes a 12-bit byte address on a 16-bit host port.
*/
`ifndef HCB_CFG_SVH
`define HCB_CFG_SVH

// host map
`define HCB_BD_BASE     12'h400
`define HCB_BD_MASK     12'hF80
`define HCB_PRM_BASE    12'h480
`define HCB_PRM_MASK    12'hFC0
`define HCB_EVENT_OFS   12'h88A
`define HCB_EVENT_CLR   12'h888
`define HCB_STATUS_OFS  12'h88C
`define HCB_MEM_WORDS   96

// parameter words as indexes into the channel memory
`define HCB_P_FCODE     7'h40
`define HCB_P_MAX_RX_BUFFER_LENGTH     7'h41
`define HCB_P_CRC_LO    7'h4E
`define HCB_P_CRC_HI    7'h4F
`define HCB_P_DROP      7'h50
`define HCB_P_CRCERR    7'h51
`define HCB_P_ABORT     7'h52
`define HCB_P_NOMATCH   7'h53
`define HCB_P_RETRY     7'h54
`define HCB_P_MAX_FRAME_LENGTH      7'h55
`define HCB_P_ADDRESS_COMPARE_MASK     7'h56
`define HCB_P_HADDR     7'h57

// descriptor control word bits
`define HCB_BD_E        15
`define HCB_BD_X        14
`define HCB_BD_W        13
`define HCB_BD_I        12

// event bits
`define HCB_EV_RXB      0
`define HCB_EV_TXB      1
`define HCB_EV_BSY      2
`define HCB_EV_RXF      3
`define HCB_EV_TXE      4
`define HCB_EV_IDL      5
`define HCB_EV_CD       6
`define HCB_EV_CTS      7
`define HCB_EV_RST      8'h00
`define HCB_MASK_RST    8'h00

`endif

/* File: hdl/hcb_channel.sv */
/*
  hdlc channel: event/mask/status registers, parameter memory,
  receive and transmit descriptor rings, link-clock handshakes.
  assumes a framed byte stream from the transceiver on its own clock.
*/
`include "hcb_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// three-stage synchroniser, output moves once stages two and three agree
module hcb_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_d,
  output logic      o_q
);
  logic s1_ff, s2_ff, s3_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      o_q   <= 1'b0;
    end else begin
      s1_ff <= i_d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) o_q <= s3_ff;
    end
  end
endmodule // hcb_sync3

////////////////////////////////////////////////////////////////////////////
// What this block does
// (R01) no empty buffer: drop frame, busy event
// (R02) sent buffer sets tx event if interrupt
// (R03) partial receive buffer event if interrupt
// (R04) mask bits mirror event bits
// (R05) idle/carrier status bits from carrier, idle
// (R06) status bit 0 mirrors clear-to-send negated
// (R07) 32 parameter words per channel
// (R08) software keeps function codes below seven
// (R09) bytes per buffer limited by max length
// (R10) software loads documented crc constants
// (R11) count drops, crc errors, aborts
// (R12) count unmatched frames and retransmissions
// (R13) long frame truncated, length violation flagged
// (R14) address mask plus four byte-swapped addresses
// (R15) eight receive descriptors, four words each
// (R16) receive close clears empty, sets errors
// (R17) receive only into empty-marked buffers
// (R18) wrap bit returns ring to first
// (R19) external bit selects buffer memory
// (R20) frame event unless aborted; first/last marked
// (R21) close flags nonoctet, abort, crc, overrun, carrier
// (R22) transmit close clears ready, sets errors
// (R23) event flags clear on written ones
// (R24) interrupt when flag and mask set
// (R25) accept frame on any masked address match
module hcb_channel (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_lnk_clk,
  input  wire logic [11:0]           i_host_addr,
  input  wire logic                  i_host_wr,
  input  wire logic                  i_host_rd,
  input  wire logic [15:0]           i_host_wdata,
  output logic      [15:0]           o_host_rdata,
  input  wire logic                  i_receiver_enable,
  input  wire logic                  i_transmitter_enable,
  input  wire logic                  i_nonmultiplexed_serial_mode,
  input  wire logic                  i_carrier_detect_n,
  input  wire logic                  i_clear_to_send_n,
  input  wire logic                  i_line_idle,
  input  wire logic                  i_lnk_rx_valid,
  input  wire hcb_pkg::hcb_rx_item_t i_lnk_rx,
  output logic                       o_lnk_tx_start,
  output hcb_pkg::hcb_tx_req_t       o_lnk_tx,
  input  wire logic                  i_lnk_tx_done,
  input  wire hcb_pkg::hcb_tx_done_t i_lnk_tx_status,
  output logic                       o_dma_wr,
  output hcb_pkg::hcb_dma_t          o_dma,
  output logic                       o_irq
);
  import hcb_pkg::*;

  function automatic logic [6:0] bd_word(input logic tx,
                                         input logic [2:0] idx);
    return {1'b0, tx, idx, 2'b00};
  endfunction

  function automatic logic addr_match(input logic [15:0] a,
                                      input logic [15:0] m,
                                      input logic [15:0] h);
    return ((a ^ h) & m) == 16'h0000;
  endfunction

  logic [15:0]  mem_ff [0:`HCB_MEM_WORDS-1];
  logic [7:0]   ev_ff, mask_ff;
  hcb_rx_st_t   rx_state_ff, nxt_rx_state;
  hcb_tx_st_t   tx_state_ff;
  logic [2:0]   rx_idx_ff, tx_idx_ff;
  logic [15:0]  rx_cnt_ff, rx_tot_ff;
  logic [7:0]   rx_addr_lo_ff;
  logic         rx_first_ff, rx_lg_ff, rx_ov_ff, rx_cd_ff, rx_nobuf_ff;
  logic         rx_ack_ff, tx_req_ff;
  hcb_tx_req_t  tx_hold_ff;
  hcb_rx_item_t lrx_hold_ff;
  logic         lrx_req_ff, lrx_ov_ff, lrx_pend_ff;
  logic         ltx_busy_ff, ltx_seen_ff, ltx_ack_ff;
  hcb_tx_done_t ltx_done_ff;
  logic         cd_q_ff, cts_q_ff, id_q_ff;

  ////////////////////////////////////////////////////////////////////////
  // crossings and pin synchronisers
  logic rx_req_s, tx_ack_s, lrx_ack_s, ltx_req_s, cd_s, cts_s, idle_s;
  hcb_sync3 u_rxreq (.i_clk(i_core_clk), .i_rst(i_sys_rst),
                     .i_d(lrx_req_ff), .o_q(rx_req_s));
  hcb_sync3 u_txack (.i_clk(i_core_clk), .i_rst(i_sys_rst),
                     .i_d(ltx_ack_ff), .o_q(tx_ack_s));
  hcb_sync3 u_rxack (.i_clk(i_lnk_clk), .i_rst(i_sys_rst),
                     .i_d(rx_ack_ff), .o_q(lrx_ack_s));
  hcb_sync3 u_txreq (.i_clk(i_lnk_clk), .i_rst(i_sys_rst),
                     .i_d(tx_req_ff), .o_q(ltx_req_s));
  hcb_sync3 u_cd    (.i_clk(i_core_clk), .i_rst(i_sys_rst),
                     .i_d(i_carrier_detect_n), .o_q(cd_s));
  hcb_sync3 u_cts   (.i_clk(i_core_clk), .i_rst(i_sys_rst),
                     .i_d(i_clear_to_send_n), .o_q(cts_s));
  hcb_sync3 u_idle  (.i_clk(i_core_clk), .i_rst(i_sys_rst),
                     .i_d(i_line_idle), .o_q(idle_s));

  ////////////////////////////////////////////////////////////////////////
  // link side: hold a received item until the core acknowledges it
  always_ff @(posedge i_lnk_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lrx_hold_ff <= '0;
      lrx_req_ff  <= 1'b0;
      lrx_ov_ff   <= 1'b0;
      lrx_pend_ff <= 1'b0;
    end else if (i_lnk_rx_valid) begin
      if (lrx_req_ff == lrx_ack_s) begin
        lrx_hold_ff <= i_lnk_rx;
        lrx_ov_ff   <= lrx_pend_ff;
        lrx_pend_ff <= 1'b0;
        lrx_req_ff  <= ~lrx_req_ff;
      end else begin
        lrx_pend_ff <= 1'b1;  // item lost: overrun reported on next
      end
    end
  end

  // link side: launch a transmit buffer, return its status
  always_ff @(posedge i_lnk_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_lnk_tx_start <= 1'b0;
      o_lnk_tx       <= '0;
      ltx_busy_ff    <= 1'b0;
      ltx_seen_ff    <= 1'b0;
      ltx_ack_ff     <= 1'b0;
      ltx_done_ff    <= '0;
    end else begin
      o_lnk_tx_start <= 1'b0;
      if (!ltx_busy_ff && ltx_req_s != ltx_seen_ff) begin
        o_lnk_tx_start <= 1'b1;
        o_lnk_tx       <= tx_hold_ff;
        ltx_busy_ff    <= 1'b1;
        ltx_seen_ff    <= ltx_req_s;
      end else if (ltx_busy_ff && i_lnk_tx_done) begin
        ltx_busy_ff <= 1'b0;
        ltx_done_ff <= i_lnk_tx_status;
        ltx_ack_ff  <= ltx_seen_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive decode
  hcb_rx_item_t item;
  assign item = lrx_hold_ff;
  wire [6:0]  rx_bd   = bd_word(1'b0, rx_idx_ff);
  wire [15:0] rx_cs   = mem_ff[rx_bd];
  wire [31:0] rx_ptr  = {mem_ff[rx_bd + 7'd2], mem_ff[rx_bd + 7'd3]};
  wire [15:0] max_rx_buffer_length   = mem_ff[`HCB_P_MAX_RX_BUFFER_LENGTH];
  wire [15:0] max_frame_length    = mem_ff[`HCB_P_MAX_FRAME_LENGTH];
  wire [15:0] address_compare_mask   = mem_ff[`HCB_P_ADDRESS_COMPARE_MASK];
  wire [15:0] rx_addr = {rx_addr_lo_ff, item.data};  // first byte high
  wire rx_match = addr_match(rx_addr, address_compare_mask, mem_ff[`HCB_P_HADDR])     //R25
    | addr_match(rx_addr, address_compare_mask, mem_ff[`HCB_P_HADDR + 7'd1])          //R14
    | addr_match(rx_addr, address_compare_mask, mem_ff[`HCB_P_HADDR + 7'd2])
    | addr_match(rx_addr, address_compare_mask, mem_ff[`HCB_P_HADDR + 7'd3]);
  wire [15:0] cnt_inc = rx_cnt_ff + 16'h0001;
  wire rx_new   = rx_req_s != rx_ack_ff;
  wire rx_dst   = rx_state_ff == RX_ADDR || rx_state_ff == RX_DATA;
  wire rx_empty = rx_cs[`HCB_BD_E];                                    //R17
  wire rx_err   = item.crc_bad | item.abort | item.nonoctet;
  wire rx_start = rx_new && rx_state_ff == RX_IDLE && !item.last
                  && i_receiver_enable;
  wire rx_dbyte = rx_new && rx_dst && !item.last;
  wire rx_long  = rx_dbyte && rx_tot_ff >= max_frame_length;                       //R13
  wire rx_byte  = rx_dbyte && !rx_long && rx_empty;
  wire rx_nomat = rx_byte && rx_state_ff == RX_ADDR && !rx_match;
  wire rx_part  = rx_byte && !rx_nomat && cnt_inc == max_rx_buffer_length;            //R09
  wire rx_end   = rx_new && rx_dst && item.last;
  wire rx_close = (rx_end && rx_empty) || rx_part;
  wire rx_bsy   = (rx_start || (rx_dbyte && !rx_long)) && !rx_empty;   //R01
  wire rx_dend  = rx_new && rx_state_ff == RX_DROP && item.last;
  wire rx_store = rx_byte || (rx_start && rx_empty);
  // close word: empty cleared, last/first marked, errors in 5-0
  wire [5:0] rx_errs = rx_end ? {rx_lg_ff, item.nonoctet, item.abort,
      item.crc_bad, rx_ov_ff | lrx_ov_ff, rx_cd_ff} : 6'h00;           //R21
  wire [15:0] rx_cw  = {1'b0, rx_cs[14:12], rx_end, rx_first_ff,
                        rx_cs[9:6], rx_errs};                          //R16
  wire [15:0] rx_len = rx_end ? rx_cnt_ff : cnt_inc;
  wire rx_ctr_we = (rx_dend && (rx_nobuf_ff || !rx_err))
                   || (rx_end && (item.abort || item.crc_bad));
  wire [6:0] rx_ctr_idx = rx_dend ? (rx_nobuf_ff ? `HCB_P_DROP         //R11
                                                : `HCB_P_NOMATCH)      //R12
                        : item.abort ? `HCB_P_ABORT : `HCB_P_CRCERR;

  // receive state selection
  always_comb begin
    nxt_rx_state = rx_state_ff;
    unique case (rx_state_ff)
      RX_IDLE: if (rx_start) nxt_rx_state = rx_empty ? RX_ADDR : RX_DROP;
      RX_ADDR, RX_DATA: begin
        if (rx_end) nxt_rx_state = RX_IDLE;
        else if (rx_bsy || rx_nomat) nxt_rx_state = RX_DROP;
        else if (rx_byte) nxt_rx_state = RX_DATA;
      end
      RX_DROP: if (rx_dend) nxt_rx_state = RX_IDLE;
    endcase
  end

  // receive sequencing
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_state_ff <= RX_IDLE;
      rx_idx_ff   <= 3'h0;
      rx_cnt_ff   <= 16'h0000;
      rx_tot_ff   <= 16'h0000;
      rx_addr_lo_ff <= 8'h00;
      {rx_first_ff, rx_lg_ff, rx_ov_ff, rx_cd_ff, rx_nobuf_ff} <= 5'h00;
      rx_ack_ff   <= 1'b0;
      o_dma_wr    <= 1'b0;
      o_dma       <= '0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_ack_ff   <= rx_req_s;
      o_dma_wr    <= rx_store;
      if (rx_store)                                                    //R19
        o_dma <= '{addr: rx_ptr + {16'h0000, rx_cnt_ff},
                   data: item.data, ext: rx_cs[`HCB_BD_X]};
      if (rx_close)
        rx_idx_ff <= rx_cs[`HCB_BD_W] ? 3'h0 : rx_idx_ff + 3'h1;      //R18
      if (rx_start) begin
        rx_cnt_ff     <= rx_empty ? 16'h0001 : 16'h0000;
        rx_tot_ff     <= 16'h0001;
        rx_addr_lo_ff <= item.data;
        {rx_first_ff, rx_lg_ff, rx_ov_ff, rx_cd_ff} <= 4'h8;           //R20
        rx_nobuf_ff   <= !rx_empty;
      end else begin
        if (rx_part || rx_nomat || rx_end || rx_dend) rx_cnt_ff <= 16'h0000;
        else if (rx_byte) rx_cnt_ff <= cnt_inc;
        if (rx_byte) rx_tot_ff <= rx_tot_ff + 16'h0001;
        if (rx_part) rx_first_ff <= 1'b0;
        if (rx_long) rx_lg_ff <= 1'b1;
        if (rx_bsy) rx_nobuf_ff <= 1'b1;
        if (rx_new && lrx_ov_ff) rx_ov_ff <= 1'b1;
        if (rx_dst && cd_s && i_nonmultiplexed_serial_mode)
          rx_cd_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit ring
  wire [6:0]  tx_bd   = bd_word(1'b1, tx_idx_ff);
  wire [15:0] tx_cs   = mem_ff[tx_bd];
  wire tx_go    = tx_state_ff == TX_IDLE && i_transmitter_enable
                  && tx_cs[`HCB_BD_E];
  wire tx_fin   = tx_state_ff == TX_WAIT && tx_ack_s == tx_req_ff;
  wire tx_coll  = tx_fin && ltx_done_ff.collision;
  wire tx_close = tx_fin && !ltx_done_ff.collision;
  wire tx_err   = ltx_done_ff.underrun | ltx_done_ff.cts_lost;
  wire [15:0] tx_cw = {1'b0, tx_cs[14:2], ltx_done_ff.underrun,
                       ltx_done_ff.cts_lost};                          //R22

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_state_ff <= TX_IDLE;
      tx_idx_ff   <= 3'h0;
      tx_req_ff   <= 1'b0;
      tx_hold_ff  <= '0;
    end else begin
      if (tx_go || tx_coll) begin  // collision resends the same buffer
        tx_req_ff   <= ~tx_req_ff;
        tx_state_ff <= TX_WAIT;
        tx_hold_ff  <= '{len: mem_ff[tx_bd + 7'd1],
          ptr: {mem_ff[tx_bd + 7'd2], mem_ff[tx_bd + 7'd3]},
          ext: tx_cs[`HCB_BD_X]};
      end else if (tx_close) begin
        tx_state_ff <= TX_IDLE;
        tx_idx_ff   <= tx_cs[`HCB_BD_W] ? 3'h0 : tx_idx_ff + 3'h1;    //R18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel memory: descriptors and parameter words
  wire host_bd  = (i_host_addr & `HCB_BD_MASK) == `HCB_BD_BASE;
  wire host_prm = (i_host_addr & `HCB_PRM_MASK) == `HCB_PRM_BASE;    //R07
  wire [6:0] host_idx = host_bd ? {1'b0, i_host_addr[6:1]}
                                : `HCB_P_FCODE + {2'b00, i_host_addr[5:1]};

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `HCB_MEM_WORDS; i++) mem_ff[i] <= 16'h0000;
    end else begin
      if (i_host_wr && (host_bd || host_prm))
        mem_ff[host_idx] <= i_host_wdata;
      if (rx_close) begin                                              //R15
        mem_ff[rx_bd]         <= rx_cw;
        mem_ff[rx_bd + 7'd1]  <= rx_len;
      end
      if (rx_ctr_we) mem_ff[rx_ctr_idx] <= mem_ff[rx_ctr_idx] + 16'h0001;
      if (tx_close) mem_ff[tx_bd] <= tx_cw;
      if (tx_coll)                                                     //R12
        mem_ff[`HCB_P_RETRY] <= mem_ff[`HCB_P_RETRY] + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events, mask, line status
  wire [7:0] line_status = {5'h00, cd_s | idle_s, cd_s, cts_s};   //R05 R06
  wire [7:0] ev_set;
  assign ev_set[`HCB_EV_RXB] = (rx_part || (rx_end && rx_empty
                               && item.abort)) && rx_cs[`HCB_BD_I];    //R03
  assign ev_set[`HCB_EV_TXB] = tx_close && !tx_err && tx_cs[`HCB_BD_I];//R02
  assign ev_set[`HCB_EV_BSY] = rx_bsy;                                 //R01
  assign ev_set[`HCB_EV_RXF] = rx_end && !item.abort;                  //R20
  assign ev_set[`HCB_EV_TXE] = tx_close && tx_err;
  assign ev_set[`HCB_EV_IDL] = line_status[2] != id_q_ff;
  assign ev_set[`HCB_EV_CD]  = cd_s != cd_q_ff;
  assign ev_set[`HCB_EV_CTS] = cts_s != cts_q_ff;
  wire ev_wr = i_host_wr && i_host_addr == `HCB_EVENT_CLR;
  wire [7:0] ev_clr = ev_wr ? i_host_wdata[15:8] : 8'h00;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_ff   <= `HCB_EV_RST;
      mask_ff <= `HCB_MASK_RST;
      {id_q_ff, cd_q_ff, cts_q_ff} <= 3'h0;
    end else begin
      ev_ff <= (ev_ff & ~ev_clr) | ev_set;  // set beats clear         //R23
      if (i_host_wr && i_host_addr == `HCB_EVENT_OFS)
        mask_ff <= i_host_wdata[15:8];                                 //R04
      {id_q_ff, cd_q_ff, cts_q_ff} <= line_status[2:0];
    end
  end

  assign o_irq = |(ev_ff & mask_ff);                                   //R24

  // host read, 8-bit registers on the upper byte lane
  wire [15:0] rd_mux =
      (i_host_addr == `HCB_EVENT_CLR)  ? {ev_ff, 8'h00} :
      (i_host_addr == `HCB_EVENT_OFS)  ? {mask_ff, 8'h00} :
      (i_host_addr == `HCB_STATUS_OFS) ? {line_status, 8'h00} :
      (host_bd || host_prm)            ? mem_ff[host_idx] : 16'h0000;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) o_host_rdata <= 16'h0000;
    else if (i_host_rd) o_host_rdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_last_byte;
    rx_end && rx_empty;
  endsequence

  irq_from_mask_a: assert property (o_irq == |(ev_ff & mask_ff)) //R24
    else $error("interrupt does not follow flags and mask");
  busy_event_a: assert property (rx_bsy |=> ev_ff[`HCB_EV_BSY]) //R01
    else $error("busy event missing after drop");
  txb_gated_a: assert property (tx_close && !tx_cs[`HCB_BD_I] //R02
    |=> !ev_ff[`HCB_EV_TXB] || $past(ev_ff[`HCB_EV_TXB]))
    else $error("tx buffer event without interrupt bit");
  flag_sticky_a: assert property (!ev_wr |=> //R23
    (ev_ff & $past(ev_ff)) == $past(ev_ff))
    else $error("event flag lost without a write");
  flag_clear_a: assert property (ev_wr && ev_set == 8'h00 //R23
    |=> ev_ff == ($past(ev_ff) & ~$past(ev_clr)))
    else $error("event clear by written ones failed");
  frame_event_a: assert property (s_last_byte ##0 !item.abort //R20
    |=> ev_ff[`HCB_EV_RXF] ##1 ev_ff[`HCB_EV_RXF] || $past(ev_wr))
    else $error("frame received event missing");
  buf_limit_a: assert property (o_dma_wr |-> rx_cnt_ff <= max_rx_buffer_length) //R09
    else $error("receive buffer overfilled");
  empty_clear_a: assert property (rx_close |=> //R16
    !mem_ff[$past(rx_bd)][`HCB_BD_E] || $past(i_host_wr))
    else $error("closed buffer still marked empty");
  ring_wrap_a: assert property (rx_close && rx_cs[`HCB_BD_W] //R18
    |=> rx_idx_ff == 3'h0)
    else $error("receive ring did not wrap");
  status_read_a: assert property (i_host_rd //R06
    && i_host_addr == `HCB_STATUS_OFS |=> o_host_rdata[8] == $past(cts_s))
    else $error("status bit 0 wrong");
endmodule // hcb_channel

/* File: hdl/hcb_pkg.sv */
/*
  types shared by the hdlc channel block.
  assumes nothing beyond the config header.
*/
package hcb_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       crc_bad;
    logic       abort;
    logic       nonoctet;
  } hcb_rx_item_t;

  typedef struct packed {
    logic [15:0] len;
    logic [31:0] ptr;
    logic        ext;
  } hcb_tx_req_t;

  typedef struct packed {
    logic underrun;
    logic cts_lost;
    logic collision;
  } hcb_tx_done_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
    logic        ext;
  } hcb_dma_t;

  typedef enum logic [1:0] {RX_IDLE, RX_ADDR, RX_DATA, RX_DROP} hcb_rx_st_t;
  typedef enum logic {TX_IDLE, TX_WAIT} hcb_tx_st_t;
endpackage

/* File: testbench/hcb_channel_tb.sv */
/*
  self-checking bench for the hdlc channel: registers, status pins,
  receive ring with drop and wrap, one transmit buffer.
  assumes hcb_link_model on the far side of the link.
*/
module hcb_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hcb_pkg::*;

  logic         clk, lclk, rst, wr, rd, ren, ten, nonmultiplexed_serial_mode, cd_n, cts_n, idle;
  logic [11:0]  addr;
  logic [15:0]  wdata, rdata, v;
  logic         rx_v, tx_start, tx_done, dma_wr, irq, exp_ext;
  hcb_rx_item_t rx;
  hcb_tx_req_t  tx;
  hcb_tx_done_t tx_st;
  hcb_dma_t     dma;
  logic [39:0]  exp_q[$];
  int           err_count, n_compared, i;

  // core clock 50 MHz, link clock 160 ns unrelated in phase
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #37;
    forever #80 lclk = ~lclk;
  end

  hcb_channel uut (.i_core_clk(clk), .i_sys_rst(rst), .i_lnk_clk(lclk),
    .i_host_addr(addr), .i_host_wr(wr), .i_host_rd(rd),
    .i_host_wdata(wdata), .o_host_rdata(rdata), .i_receiver_enable(ren),
    .i_transmitter_enable(ten), .i_nonmultiplexed_serial_mode(nonmultiplexed_serial_mode),
    .i_carrier_detect_n(cd_n), .i_clear_to_send_n(cts_n),
    .i_line_idle(idle), .i_lnk_rx_valid(rx_v), .i_lnk_rx(rx),
    .o_lnk_tx_start(tx_start), .o_lnk_tx(tx), .i_lnk_tx_done(tx_done),
    .i_lnk_tx_status(tx_st), .o_dma_wr(dma_wr), .o_dma(dma), .o_irq(irq));

  hcb_link_model link (.i_lnk_clk(lclk), .i_tx_start(tx_start), .i_tx(tx),
    .o_rx_valid(rx_v), .o_rx(rx), .o_tx_done(tx_done),
    .o_tx_status(tx_st));

  ////////////////////////////////////////////////////////////////////////
  // compare, host cycles, verdict
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hw(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic hr(input logic [11:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d  = rdata;
  endtask
  task automatic hrc(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] d;
    hr(a, d);
    chk(d, e);
  endtask
  // read a control word until its ownership bit drops, bounded
  task automatic poll(input logic [11:0] a);
    v = 16'h8000;
    for (int k = 0; k < 200 && v[15]; k++) hr(a, v);
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // every memory write checked against the queued model bytes
  always @(negedge clk) begin
    if (dma_wr === 1'b1) begin
      chk({dma.addr, dma.data}, exp_q.size() ? exp_q.pop_front() : '0);
      chk(dma.ext, exp_ext);
    end
  end

  // arm descriptor 0, send n random bytes, check the close
  task automatic rx_frame(input logic [15:0] c, input int n,
                          input logic [15:0] done_c);
    logic [7:0] b;
    hw(12'h404, 16'h0001);
    hw(12'h406, 16'h2340);
    hw(12'h400, c);
    exp_ext = c[14];
    for (int k = 0; k < n; k++) begin
      b = 8'($urandom);
      exp_q.push_back({32'h00012340 + k, b});
      link.send_item(b, 1'b0);
    end
    link.send_item(8'h00, 1'b1);
    poll(12'h400);
    chk(v, done_c);
    hrc(12'h402, 16'(n));
    chk(exp_q.size(), 0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h50b3f4af));
    {wr, rd, ten, cd_n, cts_n, idle, addr, wdata} = '0;
    {rst, ren, nonmultiplexed_serial_mode, exp_ext, err_count, n_compared} = {3'b111, 1'b0, 64'd0};
    repeat (3) @(negedge clk);
    rst = 1'b0;
    hrc(12'h88A, 16'h0000);
    hw(12'h480, 16'h5050);
    hw(12'h49C, 16'hF0B8);
    hw(12'h482, 16'h0010);
    hw(12'h4AA, 16'h0100);
    hw(12'h4AC, 16'h0000);
    hw(12'h4BE, 16'hA5C3);
    hrc(12'h482, 16'h0010);
    hrc(12'h4BE, 16'hA5C3);
    hrc(12'hFFE, 16'h0000);
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      {cd_n, cts_n, idle} = 3'($urandom);
      repeat (10) @(negedge clk);
      hrc(12'h88C, {5'h0, cd_n | idle, cd_n, cts_n, 8'h00});
    end
    // carrier back to asserted, so frames carry no carrier-lost flag
    {cd_n, cts_n, idle} = 3'h0;
    repeat (10) @(negedge clk);
    hw(12'h888, 16'hFF00);
    hrc(12'h888, 16'h0000);
    $display("test status done");
    hw(12'h88A, 16'h0800);
    rx_frame(16'hF000, 4, 16'h7C00);
    hrc(12'h888, 16'h0800);
    chk(irq, 1'b1);
    hw(12'h888, 16'h0000);
    hrc(12'h888, 16'h0800);
    hw(12'h888, 16'h0800);
    hrc(12'h888, 16'h0000);
    chk(irq, 1'b0);
    $display("test receive done");
    link.send_item(8'h01, 1'b0);
    link.send_item(8'h02, 1'b0);
    link.send_item(8'h00, 1'b1);
    repeat (20) @(negedge clk);
    hrc(12'h888, 16'h0400);
    hrc(12'h4A0, 16'h0001);
    hw(12'h888, 16'hFF00);
    rx_frame(16'hA000, 3, 16'h2C00);
    hrc(12'h888, 16'h0800);
    // unmatched address: descriptor reused, counter bumped
    hw(12'h4AC, 16'hFFFF);
    hw(12'h400, 16'h8000);
    exp_q.push_back({32'h00012340, 8'h01});
    exp_q.push_back({32'h00012341, 8'h02});
    link.send_item(8'h01, 1'b0);
    link.send_item(8'h02, 1'b0);
    link.send_item(8'h00, 1'b1);
    repeat (20) @(negedge clk);
    hrc(12'h4A6, 16'h0001);
    hrc(12'h400, 16'h8000);
    chk(exp_q.size(), 0);
    $display("test drop and wrap done");
    hw(12'h888, 16'hFF00);
    hw(12'h442, 16'h0003);
    hw(12'h444, 16'h0002);
    hw(12'h446, 16'h0100);
    hw(12'h440, 16'hB000);
    ten = 1'b1;
    poll(12'h440);
    chk(v, 16'h3000);
    chk(link.last_tx, {16'h0003, 32'h00020100, 1'b0});
    chk(link.n_tx, 1);
    hrc(12'h888, 16'h0200);
    // wrapped back to descriptor 0, interrupt bit clear: no tx event
    hw(12'h888, 16'hFF00);
    hw(12'h440, 16'hA000);
    poll(12'h440);
    chk(v, 16'h2000);
    chk(link.n_tx, 2);
    hrc(12'h888, 16'h0000);
    $display("test transmit done");
    wrap_up;
  end

  // watchdog well beyond the expected run
  initial begin
    #300us;
    err_count++;
    wrap_up;
  end
endmodule // hcb_channel_tb

/* File: testbench/hcb_link_model.sv */
/*
  transceiver model on the link clock: offers receive items, answers
  every transmit start with one done pulse.
  assumes the link clock is made by the bench.
*/
module hcb_link_model
  import hcb_pkg::*;
(
  input  wire logic         i_lnk_clk,
  input  wire logic         i_tx_start,
  input  wire hcb_tx_req_t  i_tx,
  output logic              o_rx_valid,
  output hcb_rx_item_t      o_rx,
  output logic              o_tx_done,
  output hcb_tx_done_t      o_tx_status
);
  timeunit 1ns;
  timeprecision 1ps;
  hcb_tx_req_t last_tx;
  int          n_tx;

  // idle levels at time zero
  initial begin
    o_rx_valid  = 1'b0;
    o_rx        = '0;
    o_tx_done   = 1'b0;
    o_tx_status = '0;
    n_tx        = 0;
  end

  // one item, then spacing past the acknowledge round trip
  task automatic send_item(input logic [7:0] d, input logic last);
    @(negedge i_lnk_clk);
    o_rx       = '{data: d, last: last, default: 1'b0};
    o_rx_valid = 1'b1;
    @(negedge i_lnk_clk);
    o_rx_valid = 1'b0;
    o_rx.data  = ~d;  // stale data never looks valid
    repeat (10) @(negedge i_lnk_clk);
  endtask

  // answer each start with one clean done pulse
  initial begin
    forever begin
      do @(posedge i_lnk_clk); while (i_tx_start !== 1'b1);
      last_tx = i_tx;
      n_tx++;
      repeat (6) @(negedge i_lnk_clk);
      o_tx_done = 1'b1;
      @(negedge i_lnk_clk);
      o_tx_done = 1'b0;
    end
  end
endmodule // hcb_link_model
